// ---- bench/edge_sel_props.sv ----
// checker for the edge trigger selection block
`timescale 1ns/1ps
module edge_sel_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [20:0] line_in,
  input wire logic [20:0] trigger,
  input wire logic [20:0] pending,
  input wire logic irq_req
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [20:0] lin_q;
  logic w0_q;
  always_ff @(posedge hclk) if (ce) lin_q <= line_in;
  always_ff @(posedge hclk) w0_q <= htrans[1] && hwrite && haddr[11:2] == 10'h000;
  property p_ok; hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("bus stalled");
  property p_rst; $rose(hresetn) |-> (trigger == 21'h0 && pending == 21'h0) [*2]; endproperty
  a_rst: assert property (p_rst) else $error("trigger after reset");
  property p_rsv; hrdata[31:21] == 11'h000 && !hrdata[19]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_edge; $past(ce) |-> (trigger & ~($past(line_in) ^ $past(lin_q))) == 21'h0;
  endproperty
  a_edge: assert property (p_edge) else $error("trigger without edge");
  property p_b19; !trigger[19] && !pending[19]; endproperty
  a_b19: assert property (p_b19) else $error("bit 19 active");
  property p_irq; irq_req == (pending != 21'h0); endproperty
  a_irq: assert property (p_irq) else $error("irq out of step");
  property p_set; (pending & ~$past(pending) & ~trigger) == 21'h0; endproperty
  a_set: assert property (p_set) else $error("pending without trigger");
  property p_wr;
    w0_q |=> (pending & ~$past(pending) & $past(line_in) & ~$past(lin_q)) == 21'h0;
  endproperty
  a_wr: assert property (p_wr) else $error("pending set during write");
  property p_frz;
    !ce |=> $stable(pending) && $stable(trigger) && $stable(irq_req);
  endproperty
  a_frz: assert property (p_frz) else $error("state moved while frozen");
  c_frz: cover property (!ce && (line_in ^ lin_q) != 21'h0);
  c_wr: cover property (w0_q && (line_in & ~lin_q) != 21'h0);
  c_irq: cover property ($rose(irq_req));
  c_clr: cover property ($fell(irq_req));
endmodule
bind edge_sel edge_sel_props u_props (.*);

// ---- bench/edge_sel_test.sv ----
// random and directed bench for the edge trigger selection block
`timescale 1ns/1ps
module edge_sel_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, a, d, seed = 32'hC;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, sz;
  logic hwrite = 1'b0, hreadyout, hresp, irq_req;
  logic ce = 1'b1;
  logic [20:0] line_in = 21'h0, lv = 21'h0, trigger, pending, m;
  logic [31:0] regs [2] = '{default: 32'h0};
  int error_cnt = 0, checked = 0;
  edge_sel dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .hsel(1'b1),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .line_in(line_in),
    .trigger(trigger),
    .pending(pending),
    .irq_req(irq_req)
  );
  always #2 hclk = ~hclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] merge(logic [31:0] o, a, d, logic [2:0] s);
    logic [31:0] k;
    k = s[1] ? 32'hFFFFFFFF : s[0] ? 32'hFFFF << (a[1] * 16) : 32'hFF << (a[1:0] * 8);
    return ((o & ~k) | (d & k)) & edge_sel_pkg::VALID_BITS;
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d, input logic [2:0] s = 3'h2);
    haddr <= a;
    hwrite <= w;
    hsize <= s;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    line_in <= lv;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic ln(input logic [20:0] v, et, ep);
    lv = v;
    line_in <= v;
    @(posedge hclk);
    #1;
    chk(32'(trigger), 32'(et));
    chk(32'(pending), 32'(ep));
    chk(32'(irq_req), 32'(ep != 21'h0));
    @(posedge hclk);
  endtask
  task automatic end_sim();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 32'(i * 4 + i / 2 * 56), 32'h0);
      chk(q, 32'h0);
    end
    for (int i = 0; i < 40; i++) begin
      d = rnd();
      sz = 3'(d % 3);
      a = (rnd() & 32'h4) | (rnd() & {30'h0, sz != 3'h2, sz == 3'h0});
      bus(1'b1, a, d, sz);
      regs[a[2]] = merge(regs[a[2]], a, d, sz);
      bus(1'b0, a & 32'h4, 32'h0);
      chk(q, regs[a[2]]);
    end
    $display("test registers done");
    for (int k = 0; k < 21; k++) begin
      m = 21'h1 << k;
      bus(1'b1, 32'h0, 32'(m));
      bus(1'b1, 32'h4, 32'h0);
      bus(1'b1, 32'h8, 32'(m));
      if (k == 19) begin
        ln(m, 21'h0, 21'h0);
        ln(21'h0, 21'h0, 21'h0);
      end else begin
        ln(m, m, m);
        ln(21'h0, 21'h0, m);
        ln(21'h0, 21'h0, m);
        bus(1'b1, 32'hC, 32'(m));
        bus(1'b0, 32'hC, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 32'h4, 32'(m));
        ln(m, m, m);
        ln(21'h0, m, m);
        bus(1'b1, 32'h4, 32'h0);
        bus(1'b1, 32'hC, 32'(m));
        lv = m;
        bus(1'b1, 32'h0, 32'(m));
        #1;
        chk(32'(pending), 32'h0);
        chk(32'(trigger), 32'(m));
        @(posedge hclk);
        ln(21'h0, 21'h0, 21'h0);
        bus(1'b1, 32'h8, 32'h0);
        ln(m, m, 21'h0);
        ln(21'h0, 21'h0, 21'h0);
      end
    end
    $display("test lines done");
    bus(1'b1, 32'h0, 32'h1);
    bus(1'b1, 32'h8, 32'h1);
    ce <= 1'b0;
    ln(21'h1, 21'h0, 21'h0);
    ln(21'h1, 21'h0, 21'h0);
    ce <= 1'b1;
    ln(21'h1, 21'h1, 21'h1);
    $display("test enable done");
    end_sim();
  end
endmodule

// ---- src/edge_sel.sv ----
// edge trigger selection with pending flags behind an ahb-lite slave
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module edge_sel (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [20:0] line_in,
  output logic [20:0] trigger,
  output logic [20:0] pending,
  output logic irq_req
);
  logic addr_ok;
  logic [3:0] be_a;
  logic dp_wr_q;
  logic [11:0] dp_addr_q;
  logic [3:0] dp_be_q;
  logic wr_rise;
  logic wr_fall;
  logic wr_mask;
  logic wr_pend;
  logic [31:0] rise_d;
  logic [31:0] rise_q;
  logic [31:0] fall_d;
  logic [31:0] fall_q;
  logic [31:0] mask_d;
  logic [31:0] mask_q;
  logic [31:0] lane_bits;
  logic [20:0] pend_clr;
  logic [20:0] pend_set;
  logic [20:0] trig_now;
  logic [20:0] pending_d;
  logic [20:0] line_prev_q;
  logic armed_q;
  logic [31:0] read_d;

  // transfer taken in address phase
  assign addr_ok = hsel & hready & (htrans == edge_sel_pkg::HTRANS_NONSEQ ||
                   htrans == edge_sel_pkg::HTRANS_SEQ);

  // byte lanes from size and low address bits
  always_comb begin
    case (hsize)
      edge_sel_pkg::HSIZE_BYTE: be_a = 4'(edge_sel_pkg::BE_BYTE0 << haddr[1:0]);
      edge_sel_pkg::HSIZE_HALF: be_a = haddr[1] ? edge_sel_pkg::BE_HIGH_HALF :
                                       edge_sel_pkg::BE_LOW_HALF;
      edge_sel_pkg::HSIZE_WORD: be_a = edge_sel_pkg::BE_ALL;
      default: be_a = edge_sel_pkg::BE_ALL;
    endcase
  end

  // data phase write flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q <= 1'b0;
    end else if (ce) begin
      if (hready) begin
        dp_wr_q <= addr_ok & hwrite;
      end
    end
  end

  // data phase address and byte lanes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_addr_q <= 12'h000;
      dp_be_q <= edge_sel_pkg::BE_NONE;
    end else if (ce) begin
      if (hready) begin
        dp_addr_q <= haddr[11:0];
        dp_be_q <= be_a;
      end
    end
  end

  assign wr_rise = dp_wr_q && {dp_addr_q[11:2], 2'h0} == edge_sel_pkg::OFF_RISE;
  assign wr_fall = dp_wr_q && {dp_addr_q[11:2], 2'h0} == edge_sel_pkg::OFF_FALL;
  assign wr_mask = dp_wr_q && {dp_addr_q[11:2], 2'h0} == edge_sel_pkg::OFF_MASK;
  assign wr_pend = dp_wr_q && {dp_addr_q[11:2], 2'h0} == edge_sel_pkg::OFF_PEND;

  // rising edge selection, lines 0..18 and 20
  select_reg u_rise (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .we(wr_rise),
    .be(dp_be_q),
    .wdata(hwdata),
    .value_d(rise_d),
    .value_q(rise_q)
  );

  // falling edge selection
  select_reg u_fall (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .we(wr_fall),
    .be(dp_be_q),
    .wdata(hwdata),
    .value_d(fall_d),
    .value_q(fall_q)
  );

  // interrupt mask
  select_reg u_mask (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .we(wr_mask),
    .be(dp_be_q),
    .wdata(hwdata),
    .value_d(mask_d),
    .value_q(mask_q)
  );

  // arm the detector one cycle after reset so no false edge appears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_q <= 1'b0;
    end else if (ce) begin
      armed_q <= 1'b1;
    end
  end

  // last sampled line levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_prev_q <= '0;
    end else if (ce) begin
      line_prev_q <= line_in;
    end
  end

  // per-line edge detection and pending source
  genvar i;
  generate
    for (i = 0; i < edge_sel_pkg::NUM_LINES; i++) begin : g_line
      logic rise_ev;
      logic fall_ev;
      assign rise_ev = armed_q & line_in[i] & ~line_prev_q[i];
      assign fall_ev = armed_q & ~line_in[i] & line_prev_q[i];
      assign trig_now[i] = (rise_ev & rise_q[i]) | (fall_ev & fall_q[i]);
      assign pend_set[i] = mask_q[i] & ((rise_ev & rise_q[i] & ~wr_rise) |
                           (fall_ev & fall_q[i]));
    end
  endgenerate

  // write-one-to-clear on the pending register
  always_comb begin
    lane_bits = {{8{dp_be_q[3]}}, {8{dp_be_q[2]}}, {8{dp_be_q[1]}}, {8{dp_be_q[0]}}};
    pend_clr = wr_pend ? hwdata[20:0] & lane_bits[20:0] & edge_sel_pkg::VALID_BITS[20:0] :
               21'h000000;
    pending_d = (pending & ~pend_clr) | pend_set;
  end

  // pending flags, a set beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending <= '0;
    end else if (ce) begin
      pending <= pending_d;
    end
  end

  // interrupt request follows the pending flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_req <= 1'b0;
    end else if (ce) begin
      irq_req <= |pending_d;
    end
  end

  // one-cycle trigger pulse per selected edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trigger <= '0;
    end else if (ce) begin
      trigger <= trig_now;
    end
  end

  // read mux uses next values so a read right after a write sees it
  always_comb begin
    case ({haddr[11:2], 2'h0})
      edge_sel_pkg::OFF_RISE: read_d = rise_d;
      edge_sel_pkg::OFF_FALL: read_d = fall_d;
      edge_sel_pkg::OFF_MASK: read_d = mask_d;
      edge_sel_pkg::OFF_PEND: read_d = {11'h000, pending_d};
      default: read_d = 32'h00000000;
    endcase
  end

  // zero-wait slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else if (ce) begin
      hreadyout <= 1'b1;
    end
  end

  // response always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else if (ce) begin
      hresp <= 1'b0;
    end
  end

  // read data taken in the address phase, held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ce) begin
      if (addr_ok & ~hwrite) begin
        hrdata <= read_d;
      end
    end
  end
endmodule

// ---- src/edge_sel_pkg.sv ----
// constants for the rising/falling edge trigger selection block
// Notes on behaviour
// - word, half-word and byte register access
// - rising select at 0x00, resets to zero
// - bits 0 to 18 enable rising edge
// - bit 20 enables rising edge, read/write
// - edge detection only, no spurious pulses
// - rising-select write blocks rising pending set
// - both selected means both edges trigger
// - masked selected edge sets pending, W1C
// - falling select register at offset 0x04
package edge_sel_pkg;
  localparam int NUM_LINES = 21;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_RISE = 12'h000;
  localparam logic [11:0] OFF_FALL = 12'h004;
  localparam logic [11:0] OFF_MASK = 12'h008;
  localparam logic [11:0] OFF_PEND = 12'h00C;
  localparam logic [31:0] VALID_BITS = 32'h0017FFFF;
  localparam logic [31:0] RESET_VALUE = 32'h00000000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [3:0] BE_NONE = 4'h0;
  localparam logic [3:0] BE_ALL = 4'hF;
  localparam logic [3:0] BE_LOW_HALF = 4'h3;
  localparam logic [3:0] BE_HIGH_HALF = 4'hC;
  localparam logic [3:0] BE_BYTE0 = 4'h1;
endpackage

// ---- src/select_reg.sv ----
// byte-lane writable 32-bit register with reserved bits held at zero
`timescale 1ns/1ps
module select_reg (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic we,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  output logic [31:0] value_d,
  output logic [31:0] value_q
);
  logic [31:0] lane_mask;

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign lane_mask[8*b +: 8] = {8{we & be[b]}};
    end
  endgenerate

  // only addressed lanes change, reserved bits stay zero
  always_comb begin
    value_d = ((value_q & ~lane_mask) | (wdata & lane_mask)) & edge_sel_pkg::VALID_BITS;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_q <= edge_sel_pkg::RESET_VALUE;
    end else if (ce) begin
      value_q <= value_d;
    end
  end
endmodule
